// ### design/qcq_exec.sv
`timescale 1ns/1ps
module qcq_exec import qcq_pkg::*; #(
  parameter logic [15:0] OP_RESTORE = 16'h01CE // arbitrary opcode value
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [15:0] opcode,
  input wire logic [31:0] effAddr,
  input wire logic [127:0] quadAccIn,
  input wire logic [255:0] grFileIn,
  input wire logic [63:0] fr0In,
  input wire logic [63:0] fr1In,
  input wire logic [31:0] xbIn,
  input wire logic [15:0] keysIn,
  input wire logic [31:0] pcbBase,
  input wire logic supervisor,
  output logic busy,
  output logic done,
  output logic fpFault,
  output logic uiiFault,
  output logic restrictFault,
  output logic qacWe,
  output logic [127:0] qacData,
  output logic grWe,
  output logic [2:0] grSel,
  output logic [31:0] grData,
  output logic carryWe,
  output logic carryVal,
  output logic ccWe,
  output logic ccEq,
  output logic mcClr,
  output logic intInhibit,
  output logic restoreWe,
  output logic [63:0] restoreFr1,
  output logic [63:0] restoreFr0,
  output logic [255:0] restoreGr,
  output logic [31:0] restoreXb,
  output logic memReq,
  output logic memWe,
  output logic [31:0] memAddr,
  output logic [15:0] memWdata,
  input wire logic memAck,
  input wire logic [15:0] memRdata,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  typedef struct packed {
    qcq_fsm_t state;
    qcq_kind_t kind;
    logic [4:0] step;
    logic [15:0] instr;
    logic [31:0] ptr;
    logic [7:0][15:0] scr;
    logic [IMG_W-1:0] img;
    logic done, fpFault, uiiFault, rsFault, qacWe, grWe, carryWe, carryVal, ccWe, ccEq;
    logic mcClr, intInh, restoreWe, memReq, memWe;
    logic [127:0] qacData;
    logic [2:0] grSel;
    logic [31:0] grData;
    logic [31:0] memAddr;
    logic [15:0] memWdata;
    logic quadImpl;
    logic [3:0] lastFlags;
    logic awHave, wHave, bvalid, rvalid;
    logic [7:0] awAddr;
    logic [31:0] wData, rdata;
    logic [3:0] wStrb;
    logic [1:0] bresp, rresp;
  } qcq_state_t;

  qcq_state_t st;
  qcq_state_t nx;

  localparam logic [MANT_W-1:0] MANT_TOP = {1'b1, {(MANT_W-1){1'b0}}};
  localparam logic [MANT_W-1:0] MANT_ONES = {MANT_W{1'b1}};

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // quad to integer in quad form; returns {fault, mantissa, exponent}
  function automatic logic [QAC_W:0] qcq_convert(input logic [QAC_W-1:0] q, input logic rnd);
    logic [MANT_W-1:0] m, r, fm, one;
    logic [EXP_W-1:0] e, eo;
    logic [6:0] k;
    logic flt;
    m = q[QAC_W-1 -: MANT_W];
    e = q[EXP_W-1:0];
    eo = e;
    flt = 1'b0;
    r = m;
    k = 7'(e - EXP_BIAS);
    fm = MANT_ONES >> (k + 7'h01);
    one = MANT_TOP >> k;
    if (rnd ? (e > EXP_LIMIT) : (e >= EXP_LIMIT)) begin
      flt = 1'b1;
    end else if (e == EXP_LIMIT) begin
      r[MSB_AT_LIMIT] = 1'b0;
    end else if (e > EXP_BIAS) begin
      r = m & ~fm;
      if (m[MANT_W-1] && !(|(m & fm))) begin
        r = r + one;
      end
      if (rnd && (|(m & (one >> 1)))) begin
        r = r + one;
      end
    end else if (e == EXP_BIAS) begin
      eo = EXP_BIAS + 16'h0001;
      r = (m[MANT_W-1] && !(|m[FRAC_MSB:LOW_TEST_LSB])) ? (MANT_TOP | (MANT_TOP >> 1)) : '0;
      if (rnd && m[FRAC_MSB]) begin
        r = r + (MANT_TOP >> 1);
      end
    end else begin
      r = '0;
      eo = '0;
    end
    return {flt, r, eo};
  endfunction

  // rotate; returns {carry, result}
  function automatic logic [WORD_W:0] qcq_rotate(input logic [31:0] v, input logic [15:0] cmd);
    logic [6:0] n;
    logic [63:0] dw;
    logic [31:0] hw, res;
    logic c;
    n = 7'(ROT_FULL - {1'b0, cmd[ROT_CNT_W-1:0]});
    dw = {v, v};
    hw = {v[31:16], v[31:16]};
    if (cmd[ROT_HALF_BIT]) begin
      if (cmd[ROT_DIR_BIT]) begin
        res = {hw[n[3:0] +: HALF_W], v[15:0]};
        c = res[WORD_W-1];
      end else begin
        res = {hw[(HALF_W - int'(n[3:0])) +: HALF_W], v[15:0]};
        c = res[HALF_W];
      end
    end else begin
      if (cmd[ROT_DIR_BIT]) begin
        res = dw[n[4:0] +: WORD_W];
        c = res[WORD_W-1];
      end else begin
        res = dw[(WORD_W - int'(n[4:0])) +: WORD_W];
        c = res[0];
      end
    end
    return {c, res};
  endfunction

  // save area word (1..26) to register slot
  function automatic int qcq_slot(input int w);
    if (w <= 4) begin
      return 0;
    end else if (w <= 8) begin
      return 1;
    end else if (w <= 24) begin
      return 2 + (w - 9) / 2;
    end
    return 10;
  endfunction

  // ----------------------------------------------------------------
  // datapath terms
  // ----------------------------------------------------------------
  logic [QAC_W:0] conv;
  logic [WORD_W:0] circular_shift;
  logic [31:0] rotSrc, qBase, elapsedNew;
  logic [15:0] topNext, botNext, saveMask, maskNow;
  logic [SAVE_SLOTS-1:0] slotNz;
  logic [2:0] instrSel;
  int wIdx, imgLsb;
  logic bitOn, doMem, mWe, fin, skip, isQuad;
  logic [31:0] mAddr;
  logic [15:0] mData;

  assign instrSel = opcode[REG_SEL_LSB +: 3];
  assign rotSrc = grFileIn[instrSel * WORD_W +: WORD_W];
  assign conv = qcq_convert(quadAccIn, opcode == OP_ROUND);
  assign circular_shift = qcq_rotate(rotSrc, effAddr[15:0]);
  assign isQuad = (opcode == OP_TRUNC) || (opcode == OP_ROUND);
  assign qBase = {st.scr[QCB_BASE_HI], st.scr[QCB_BASE_LO]};
  assign topNext = 16'(st.scr[QCB_TOP] + 16'h0001) & st.scr[QCB_MASK];
  assign botNext = 16'(st.scr[QCB_BOT] - 16'h0001) & st.scr[QCB_MASK];
  assign elapsedNew = {st.scr[2], st.scr[3]} + {st.scr[0], st.scr[1]} - st.img[31:0];
  assign wIdx = (st.step == 5'h00) ? 1 : int'(st.step);
  assign imgLsb = (SAVE_WORDS - wIdx) * HALF_W;

  // save mask from captured image
  always_comb begin
    slotNz = '0;
    saveMask = '0;
    for (int w = 1; w <= SAVE_WORDS; w++) begin
      if (|st.img[(SAVE_WORDS - w) * HALF_W +: HALF_W]) begin
        slotNz[qcq_slot(w)] = 1'b1;
      end
    end
    // mask bit order, top bits zero
    for (int s = 0; s < SAVE_SLOTS; s++) begin
      saveMask[MASK_FR1_BIT - s] = slotNz[s];
    end
  end

  assign maskNow = (st.kind == K_SAVE) ? saveMask : st.scr[0];
  assign bitOn = maskNow[MASK_FR1_BIT - qcq_slot(wIdx)];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nx = st;
    {nx.done, nx.fpFault, nx.uiiFault, nx.rsFault, nx.qacWe, nx.grWe} = '0;
    {nx.carryWe, nx.ccWe, nx.mcClr, nx.intInh, nx.restoreWe} = '0;
    doMem = 1'b0;
    mWe = 1'b0;
    mAddr = st.ptr;
    mData = '0;
    fin = 1'b0;
    skip = 1'b0;
    case (st.state)
      ST_IDLE: begin
        if (start) begin
          nx.instr = opcode;
          nx.step = '0;
          nx.ptr = effAddr;
          nx.grSel = instrSel;
          if (isQuad) begin
            nx.done = 1'b1;
            if (!st.quadImpl) begin
              nx.uiiFault = 1'b1;
            end else if (conv[QAC_W]) begin
              nx.carryWe = 1'b1;
              nx.carryVal = 1'b1;
              nx.fpFault = !keysIn[KEY_FPX_BIT];
            end else begin
              nx.qacWe = 1'b1;
              nx.qacData = conv[QAC_W-1:0];
              nx.carryWe = 1'b1;
              nx.carryVal = 1'b0;
            end
          end else if (opcode == OP_CLR_CARRY) begin
            nx.done = 1'b1;
            nx.carryWe = 1'b1;
            nx.carryVal = 1'b0;
          end else if (opcode == OP_CLR_MC) begin
            nx.done = 1'b1;
            nx.rsFault = !supervisor;
            nx.mcClr = supervisor;
            nx.intInh = supervisor;
          end else if ((opcode & OP_ROT_MASK) == OP_ROT) begin
            // write back with last bit out
            nx.done = 1'b1;
            nx.grWe = 1'b1;
            nx.grData = circular_shift[WORD_W-1:0];
            nx.carryWe = 1'b1;
            nx.carryVal = circular_shift[WORD_W];
          end else if ((opcode & OP_DQ_MASK) == OP_DQ_TOP) begin
            nx.kind = K_DQ_TOP;
            nx.state = ST_RUN;
          end else if ((opcode & OP_DQ_MASK) == OP_DQ_BOT) begin
            nx.kind = K_DQ_BOT;
            nx.state = ST_RUN;
          end else if (opcode == OP_SAVE) begin
            nx.kind = K_SAVE;
            nx.img = {fr1In, fr0In, grFileIn, xbIn};
            nx.state = ST_RUN;
          end else if (opcode == OP_RESTORE) begin
            nx.kind = K_RESTORE;
            nx.state = ST_RUN;
          end else if (opcode == OP_SLICE) begin
            if (!supervisor) begin
              nx.done = 1'b1;
              nx.rsFault = 1'b1;
            end else begin
              nx.kind = K_SLICE;
              nx.ptr = pcbBase;
              nx.img[31:0] = grFileIn[2 * WORD_W +: WORD_W];
              nx.state = ST_RUN;
            end
          end else begin
            nx.done = 1'b1;
          end
        end
      end
      ST_RUN: begin
        case (st.kind)
          K_DQ_TOP, K_DQ_BOT: begin
            if (st.step <= 5'(QCB_BASE_LO)) begin
              doMem = 1'b1;
              mAddr = st.ptr + 32'(st.step);
            end else if (st.step == 5'(DQ_FETCH)) begin
              if (st.scr[QCB_TOP] == st.scr[QCB_BOT]) begin
                fin = 1'b1;
                nx.grData = '0;
                nx.ccEq = 1'b1;
              end else begin
                doMem = 1'b1;
                mAddr = qBase + 32'((st.kind == K_DQ_TOP) ? st.scr[QCB_TOP] : botNext);
              end
            end else if (st.step == 5'(DQ_PTR)) begin
              doMem = 1'b1;
              mWe = 1'b1;
              mAddr = st.ptr + 32'((st.kind == K_DQ_TOP) ? QCB_TOP : QCB_BOT);
              mData = (st.kind == K_DQ_TOP) ? topNext : botNext;
            end else begin
              fin = 1'b1;
              nx.grData = {16'h0000, st.scr[DQ_FETCH]};
              nx.ccEq = 1'b0;
            end
          end
          K_SAVE, K_RESTORE: begin
            // one word per step in layout order
            if (st.step == 5'h00) begin
              doMem = 1'b1;
              mWe = (st.kind == K_SAVE);
              mData = saveMask;
            end else if (st.step <= 5'(SAVE_WORDS)) begin
              mAddr = st.ptr + 32'(st.step);
              mData = st.img[imgLsb +: HALF_W];
              if (bitOn) begin
                doMem = 1'b1;
                mWe = (st.kind == K_SAVE);
              end else begin
                skip = 1'b1;
                if (st.kind == K_RESTORE) begin
                  nx.img[imgLsb +: HALF_W] = '0;
                end
              end
            end else begin
              fin = 1'b1;
            end
          end
          default: begin
            // read timers, write elapsed plus interval minus slice, and new slice
            doMem = (st.step < 5'h08);
            mWe = st.step[2];
            mAddr = st.ptr + ((st.step[2] ? !st.step[1] : st.step[1]) ? PCB_ELAPSED : PCB_INTERVAL)
              + 32'(st.step[0]);
            if (st.step[1]) begin
              mData = st.step[0] ? st.img[15:0] : st.img[31:16];
            end else begin
              mData = st.step[0] ? elapsedNew[15:0] : elapsedNew[31:16];
            end
            fin = !doMem;
          end
        endcase
        if (doMem) begin
          nx.memReq = 1'b1;
          nx.memWe = mWe;
          nx.memAddr = mAddr;
          nx.memWdata = mData;
          nx.state = ST_WAIT;
        end else if (skip) begin
          nx.step = 5'(st.step + 5'h01);
        end else if (fin) begin
          nx.state = ST_IDLE;
          nx.done = 1'b1;
          nx.grWe = (st.kind == K_DQ_TOP) || (st.kind == K_DQ_BOT);
          nx.ccWe = nx.grWe;
          nx.restoreWe = (st.kind == K_RESTORE);
        end
      end
      ST_WAIT: begin
        // request held until memory acknowledges
        if (memAck) begin
          nx.memReq = 1'b0;
          if (!st.memWe) begin
            if (st.kind == K_RESTORE && st.step != 5'h00) begin
              nx.img[imgLsb +: HALF_W] = memRdata;
            end else begin
              nx.scr[st.step[2:0]] = memRdata;
            end
          end
          nx.step = 5'(st.step + 5'h01);
          nx.state = ST_RUN;
        end
      end
      default: begin
        nx.state = ST_IDLE;
      end
    endcase
    if (nx.done) begin
      nx.lastFlags = {nx.carryVal, nx.rsFault, nx.uiiFault, nx.fpFault};
    end
    // register bus writes; address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nx.awHave = 1'b1;
      nx.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nx.wHave = 1'b1;
      nx.wData = s_axi_wdata;
      nx.wStrb = s_axi_wstrb;
    end
    if (st.awHave && st.wHave) begin
      nx.awHave = 1'b0;
      nx.wHave = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = RESP_OKAY;
      if (st.awAddr == ADDR_CTRL) begin
        if (st.wStrb[0]) begin
          nx.quadImpl = st.wData[CTRL_QUAD_BIT];
        end
      end else if (st.awAddr != ADDR_STATUS) begin
        nx.bresp = RESP_SLVERR;
      end
    end else if (st.bvalid && s_axi_bready) begin
      nx.bvalid = 1'b0;
    end
    // register bus reads
    if (s_axi_arvalid && s_axi_arready) begin
      nx.rvalid = 1'b1;
      nx.rresp = RESP_OKAY;
      if (s_axi_araddr == ADDR_CTRL) begin
        nx.rdata = {31'h00000000, st.quadImpl};
      end else if (s_axi_araddr == ADDR_STATUS) begin
        nx.rdata = {27'h0000000, st.lastFlags, st.state != ST_IDLE};
      end else begin
        nx.rdata = '0;
        nx.rresp = RESP_SLVERR;
      end
    end else if (st.rvalid && s_axi_rready) begin
      nx.rvalid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.state <= ST_IDLE;
      st.kind <= K_DQ_TOP;
      st.quadImpl <= CTRL_QUAD_RST;
    end else begin
      st <= nx;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy = (st.state != ST_IDLE);
  assign {done, fpFault, uiiFault, restrictFault} = {st.done, st.fpFault, st.uiiFault, st.rsFault};
  assign {qacWe, qacData, grWe, grSel, grData} = {st.qacWe, st.qacData, st.grWe, st.grSel, st.grData};
  assign {carryWe, carryVal, ccWe, ccEq} = {st.carryWe, st.carryVal, st.ccWe, st.ccEq};
  assign {mcClr, intInhibit, restoreWe} = {st.mcClr, st.intInh, st.restoreWe};
  assign {restoreFr1, restoreFr0, restoreGr, restoreXb} = st.img;
  assign {memReq, memWe, memAddr, memWdata} = {st.memReq, st.memWe, st.memAddr, st.memWdata};
  assign s_axi_awready = !st.awHave && !st.bvalid;
  assign s_axi_wready = !st.wHave && !st.bvalid;
  assign {s_axi_bvalid, s_axi_bresp} = {st.bvalid, st.bresp};
  assign s_axi_arready = !st.rvalid;
  assign {s_axi_rvalid, s_axi_rdata, s_axi_rresp} = {st.rvalid, st.rdata, st.rresp};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence sqTake;
    start && st.state == ST_IDLE;
  endsequence
  sequence sqQuadOn;
    isQuad && st.quadImpl;
  endsequence

  quad_uii_a: assert property (sqTake ##0 (isQuad && !st.quadImpl) |=> uiiFault && !qacWe)
    else $error("quad op without quad support did not fault");
  conv_fault_a: assert property (sqTake ##0 sqQuadOn ##0 (opcode == OP_TRUNC && quadAccIn[15:0] >= EXP_LIMIT)
    |=> carryVal && !qacWe && (fpFault == !$past(keysIn[KEY_FPX_BIT])))
    else $error("conversion exception handling wrong");
  trunc_small_a: assert property (sqTake ##0 sqQuadOn ##0 (quadAccIn[15:0] < EXP_BIAS)
    |=> qacWe && qacData == '0 && carryWe && !carryVal)
    else $error("small exponent did not give zero");
  clr_carry_a: assert property (sqTake ##0 (opcode == OP_CLR_CARRY) |=> carryWe && !carryVal && !ccWe)
    else $error("clear carry misbehaved");
  clr_mc_a: assert property (sqTake ##0 (opcode == OP_CLR_MC)
    |=> done && (mcClr == $past(supervisor)) && (intInhibit == mcClr) && (restrictFault != mcClr))
    else $error("machine check clear misbehaved");
  rot_carry_a: assert property (sqTake ##0 ((opcode & OP_ROT_MASK) == OP_ROT && effAddr[15:14] == 2'h0)
    |=> grWe && carryVal == grData[0])
    else $error("rotate carry not last bit out");
  deq_empty_a: assert property (ccWe && ccEq |-> grWe && grData == '0)
    else $error("empty dequeue left register nonzero");
  save_mask_a: assert property (sqTake ##0 (opcode == OP_SAVE) |=> ##1 memReq && memWe && memAddr == $past(effAddr, 2))
    else $error("save did not write mask first");
  slice_a: assert property (sqTake ##0 (opcode == OP_SLICE)
    |=> (restrictFault && !memReq) or (##1 memReq && !memWe && memAddr == $past(pcbBase, 2) + PCB_INTERVAL))
    else $error("slice reset start wrong");

endmodule

// ### dv/qcq_mem_model.sv
`timescale 1ns/1ps
module qcq_mem_model (
  input wire logic clk,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [31:0] memAddr,
  input wire logic [15:0] memWdata,
  output logic memAck,
  output logic [15:0] memRdata
);
  logic [15:0] mem [0:63];
  logic slow = 0;
  logic go;
  initial foreach (mem[i]) mem[i] = 16'h0;
  initial memAck = 0;
  initial memRdata = 16'h0;
  // answer on alternate cycles, so some requests wait longer
  assign go = memReq && !memAck && slow;
  // one-cycle ack; data line scrambles when not answering
  always @(posedge clk) begin
    slow <= !slow;
    memAck <= go;
    memRdata <= go ? mem[memAddr[5:0]] : ~memRdata;
    if (go && memWe) mem[memAddr[5:0]] <= memWdata;
  end
endmodule

// ### dv/quad_convert_queue_shift_exec_bench.sv
`timescale 1ns/1ps
module quad_convert_queue_shift_exec_bench;
  import qcq_pkg::*;
  logic clk = 0, rstn = 0, start = 0, supervisor = 0;
  logic [15:0] opcode = 0, keysIn = 0, memWdata, memRdata;
  logic [31:0] effAddr = 0, s_axi_wdata = 0, s_axi_rdata, memAddr, restoreXb, grData;
  logic [127:0] quadAccIn = 0, qacData;
  logic [255:0] grFileIn = 0, restoreGr;
  logic busy, done, fpFault, uiiFault, restrictFault, qacWe, grWe, carryWe, carryVal, ccWe, ccEq, mcClr;
  logic intInhibit, restoreWe, memReq, memWe, memAck, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] grSel;
  logic [63:0] restoreFr1, restoreFr0, fr0In = 0, fr1In = 0;
  logic [31:0] xbIn = 0, pcbBase = 0;
  int nFail = 0, checkCount = 0;
  qcq_exec u_qcq_exec (.s_axi_wstrb(4'hF), .*);
  qcq_mem_model u_qcq_mem_model (.*);
  initial forever #50 clk = ~clk;
  task automatic endOfTest;
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [511:0] s, input logic [511:0] e);
    checkCount++;
    if (s !== e) begin
      nFail++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask
  // --------------------------------
  // instruction and bus tasks
  // --------------------------------
  task automatic run(input logic [15:0] o, input logic [31:0] e);
    int i;
    @(posedge clk);
    start <= 1;
    opcode <= o;
    effAddr <= e;
    @(posedge clk);
    start <= 0;
    // look just after each edge so a one-cycle done pulse is not missed
    #1;
    for (i = 0; i < 200 && done !== 1'b1; i++) @(posedge clk) #1;
    chk(i < 200, 1);
    if (i == 200) endOfTest();
  endtask
  task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    @(posedge clk);
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_araddr <= a;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    s_axi_bready <= 0;
    s_axi_rready <= 0;
    chk(w ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp}, w ? {32'h0, r} : {d, r});
    chk(i < 50, 1);
    if (i == 50) endOfTest();
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    ax(0, ADDR_CTRL, 32'h1, RESP_OKAY);
    ax(0, 8'h08, 32'h0, RESP_SLVERR);
    ax(1, ADDR_STATUS, 32'h0, RESP_OKAY);
    run(OP_CLR_CARRY, 0);
    chk({carryWe, carryVal, ccWe}, 3'b100);
    run(OP_CLR_MC, 0);
    chk({restrictFault, mcClr}, 2'b10);
    supervisor <= 1;
    run(OP_CLR_MC, 0);
    chk({restrictFault, mcClr, intInhibit}, 3'b011);
    grFileIn <= 256'h80000001_00000000;
    run(OP_ROT | 16'h0080, 32'h003F);
    chk({grSel, grData, carryVal, ccWe}, {3'd1, 32'h3, 2'b10});
    run(OP_ROT | 16'h0080, 32'hC03F);
    chk({grData, carryVal}, {32'h40000001, 1'b0});
    run(OP_ROT | 16'h0080, 32'h3FC0);
    chk({grData, carryVal}, {32'h80000001, 1'b1});
    quadAccIn <= {1'b1, 111'h0, 16'h0080};
    run(OP_TRUNC, 0);
    chk({qacWe, qacData, carryVal}, {1'b1, 2'b11, 110'h0, 16'h0081, 1'b0});
    quadAccIn <= {112'h1, 16'h00E0};
    run(OP_TRUNC, 0);
    chk({qacWe, fpFault, carryWe, carryVal}, 4'b0111);
    quadAccIn <= {112'h1, 16'h00E1};
    keysIn <= 16'h0200;
    run(OP_ROUND, 0);
    chk({qacWe, fpFault, carryWe, carryVal}, 4'b0011);
    quadAccIn <= {112'hFF, 16'h007F};
    run(OP_ROUND, 0);
    chk({qacWe, qacData}, {1'b1, 128'h0});
    ax(1, ADDR_CTRL, 32'h0, RESP_OKAY);
    run(OP_TRUNC, 0);
    chk({uiiFault, qacWe}, 2'b10);
    u_qcq_mem_model.mem[0] = 16'h2;
    u_qcq_mem_model.mem[1] = 16'h5;
    u_qcq_mem_model.mem[2] = 16'h7;
    u_qcq_mem_model.mem[4] = 16'h10;
    u_qcq_mem_model.mem[18] = 16'hBEEF;
    run(OP_DQ_TOP | 16'h0100, 0);
    chk({grWe, grSel, grData, ccEq, u_qcq_mem_model.mem[0]}, {1'b1, 3'd2, 32'hBEEF, 1'b0, 16'h3});
    run(OP_DQ_BOT, 32'h20);
    chk({grWe, grData, ccEq}, {1'b1, 32'h0, 1'b1});
    grFileIn <= 256'h12345678;
    xbIn <= 32'h0000ABCD;
    run(OP_SAVE, 32'h24);
    chk({u_qcq_mem_model.mem[36], u_qcq_mem_model.mem[59], u_qcq_mem_model.mem[60], u_qcq_mem_model.mem[62]},
      64'h0006_1234_5678_ABCD);
    // stale data under a clear mask bit, fresh data under set bits
    u_qcq_mem_model.mem[37] = 16'hFFFF;
    u_qcq_mem_model.mem[60] = 16'h9ABC;
    u_qcq_mem_model.mem[62] = 16'h1111;
    run(u_qcq_exec.OP_RESTORE, 32'h24);
    chk({restoreWe, restoreFr1, restoreGr, restoreXb}, {1'b1, 64'h0, 256'h12349ABC, 32'h1111});
    // slice reset: elapsed 0x100, interval 0x20, slice register 5
    grFileIn <= 256'h00000005_00000000_00000000;
    u_qcq_mem_model.mem[11] = 16'h0100;
    u_qcq_mem_model.mem[17] = 16'h0020;
    run(OP_SLICE, 0);
    chk({u_qcq_mem_model.mem[10], u_qcq_mem_model.mem[11], u_qcq_mem_model.mem[16], u_qcq_mem_model.mem[17]},
      64'h0000_011B_0000_0005);
    endOfTest();
  end
endmodule

// ### inc/qcq_pkg.sv
// Function
// - decode opcode as truncating quad-to-integer conversion
// - truncate faults at high exponent, strips otherwise
// - negative zero fraction strips then increments
// - bias exponent gives zero or minus one
// - exception keeps accumulator, else carry cleared
// - exception sets carry, faults unless keys bit
// - quad ops fault when quad unimplemented
// - rounding opcode, limit faults, clear msb fraction
// - rounding strips then adds fraction msb
// - rounding bias case adds fraction msb
// - dequeue follows pointer, loads entry into register
// - dequeue sets codes, empty zeroes register
// - clear carry leaves link and codes
// - clear machine check, inhibit interrupts, restricted
// - shift count is negated field, zero=64
// - address bits choose direction and width
// - rotate writes back, carry holds last out
// - restore loads saved or zero per mask
// - save area word layout fixed
// - save writes nonzero registers, sets mask
// - slice reset updates elapsed and interval timers
package qcq_pkg;
  // opcodes
  localparam logic [15:0] OP_TRUNC = 16'hC17A;
  localparam logic [15:0] OP_ROUND = 16'hC17B;
  localparam logic [15:0] OP_CLR_CARRY = 16'hC080;
  localparam logic [15:0] OP_CLR_MC = 16'h0012;
  localparam logic [15:0] OP_SAVE = 16'h01CD;
  localparam logic [15:0] OP_SLICE = 16'h0149;
  localparam logic [15:0] OP_DQ_TOP = 16'h605A;
  localparam logic [15:0] OP_DQ_BOT = 16'h605B;
  localparam logic [15:0] OP_DQ_MASK = 16'hFC7F;
  localparam logic [15:0] OP_ROT = 16'h5000;
  localparam logic [15:0] OP_ROT_MASK = 16'hFC00;
  localparam int REG_SEL_LSB = 7;
  // quad accumulator layout: mantissa above, exponent below
  localparam int QAC_W = 128;
  localparam int MANT_W = 112;
  localparam int EXP_W = 16;
  localparam logic [15:0] EXP_BIAS = 16'h0080;
  localparam logic [15:0] EXP_LIMIT = 16'h00E0;
  localparam int MSB_AT_LIMIT = 14;
  localparam int FRAC_MSB = 110;
  localparam int LOW_TEST_LSB = 16;
  localparam int KEY_FPX_BIT = 9;
  // shift command
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int ROT_CNT_W = 6;
  localparam logic [6:0] ROT_FULL = 7'h40;
  localparam int ROT_DIR_BIT = 15;
  localparam int ROT_HALF_BIT = 14;
  // queue control block and process block word offsets
  localparam int QCB_TOP = 0;
  localparam int QCB_BOT = 1;
  localparam int QCB_MASK = 2;
  localparam int QCB_BASE_HI = 3;
  localparam int QCB_BASE_LO = 4;
  localparam int DQ_FETCH = 5;
  localparam int DQ_PTR = 6;
  localparam logic [31:0] PCB_ELAPSED = 32'h0000000A;
  localparam logic [31:0] PCB_INTERVAL = 32'h00000010;
  // save area
  localparam int SAVE_WORDS = 26;
  localparam int SAVE_SLOTS = 11;
  localparam int MASK_FR1_BIT = 11;
  localparam int IMG_W = 416;
  // register bus
  localparam int AXI_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_QUAD_BIT = 0;
  localparam logic CTRL_QUAD_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_RUN = 3'b010, ST_WAIT = 3'b100} qcq_fsm_t;
  typedef enum logic [4:0] {
    K_DQ_TOP = 5'b00001, K_DQ_BOT = 5'b00010, K_SAVE = 5'b00100, K_RESTORE = 5'b01000, K_SLICE = 5'b10000
  } qcq_kind_t;
endpackage
